// ---- rtl/sbsr_params.svh ----
// Constants of the status byte and service request block.
// Assumes inclusion by bare name from files that need bit positions or reset values.
`ifndef SBSR_PARAMS_SVH
`define SBSR_PARAMS_SVH

`define SBSR_BIT_MEAS   0
`define SBSR_BIT_ERRQ   2
`define SBSR_BIT_QUES   3
`define SBSR_BIT_RESP   4
`define SBSR_BIT_STDEV  5
`define SBSR_BIT_RQS    6
`define SBSR_BIT_OPER   7
`define SBSR_USED_MASK  8'hBD
`define SBSR_MASK_RST   8'h00
`define SBSR_BYTE_RST   8'h00

`endif

// ---- rtl/sbsr_pkg.sv ----
// Types shared by the status byte and service request block.
// Assumes the shared constants header is reachable by its bare name.
`include "sbsr_params.svh"
package sbsr_pkg;
	typedef logic [7:0] sbsr_byte_t;

	// Summary bits that are enabled by the mask; bit 1 never counts.
	function automatic sbsr_byte_t sbsr_enabled(input sbsr_byte_t summary, input sbsr_byte_t mask);
		sbsr_enabled = summary & mask & `SBSR_USED_MASK;
	endfunction
endpackage

// ---- rtl/sbsr_if.sv ----
// Carrier between the top of the status byte block and its request flag module.
// Assumes both ends run on the same clock and reset.
`timescale 1ns/1ps
interface sbsr_if;
	import sbsr_pkg::*;
	sbsr_byte_t summary;
	sbsr_byte_t mask;
	logic       poll_done;
	logic       rqs;
	logic       rise;

	modport top_side (output summary, output mask, output poll_done, input rqs, input rise);
	modport rqs_side (input summary, input mask, input poll_done, output rqs, output rise);
endinterface

// ---- rtl/sbsr_rqs.sv ----
// Request-for-service flag: set on a fresh enabled summary rise, cleared by a serial poll.
// Assumes a reset from the top module that asserts at once and is released in step with mclk.
`timescale 1ns/1ps
module sbsr_rqs
	import sbsr_pkg::*;
(
	// Clock and reset.
	input  wire logic mclk,
	input  wire logic rst_n,
	// Link to the top module.
	sbsr_if.rqs_side  link
);
	sbsr_byte_t enabled;
	sbsr_byte_t prev_reg;
	sbsr_byte_t prev_next;
	logic       rqs_reg;
	logic       rqs_next;

	always_comb
	begin
		enabled   = sbsr_enabled(link.summary, link.mask);
		prev_next = enabled;
		// A rise in the poll cycle is kept, so the new request is not lost.
		link.rise = |(enabled & ~prev_reg);
		if (link.rise)
			rqs_next = 1'b1;
		else if (link.poll_done)
			rqs_next = 1'b0;
		else
			rqs_next = rqs_reg;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev_reg <= 8'h00;
			rqs_reg  <= 1'b0;
		end
		else
		begin
			prev_reg <= prev_next;
			rqs_reg  <= rqs_next;
		end
	end

	assign link.rqs = rqs_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_rise_sets;
		link.rise |=> rqs_reg;
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("Rise did not set the request flag.");

	property p_poll_clears;
		link.poll_done && !link.rise |=> !rqs_reg;
	endproperty
	a_poll_clears: assert property (p_poll_clears) else $error("Poll did not clear the request flag.");

	property p_no_spurious_set;
		!rqs_reg && !link.rise |=> !rqs_reg;
	endproperty
	a_no_spurious_set: assert property (p_no_spurious_set) else $error("Request flag set without a rise.");
endmodule

// ---- rtl/sbsr_top.sv ----
// Status byte, request enable mask, serial poll answer and SRQ drive for a bus instrument.
// Assumes summary inputs come from logic on mclk and that command strobes are one-cycle pulses.
`timescale 1ns/1ps
`include "sbsr_params.svh"
module sbsr_top
	import sbsr_pkg::*;
(
	// Clock and reset.
	input  wire logic       mclk,
	input  wire logic       arst_n,
	// Summary messages from the register sets and queues.
	input  wire logic       meas_summary,
	input  wire logic       error_queue_nonempty,
	input  wire logic       questionable_summary,
	input  wire logic       response_pending,
	input  wire logic       standard_event_summary,
	input  wire logic       operation_summary,
	// Command strobes from the message parser.
	input  wire logic       sre_write,
	input  wire logic [7:0] sre_data,
	input  wire logic       sre_query,
	input  wire logic       stb_query,
	// Query answer.
	output logic            resp_valid,
	output logic [7:0]      resp_data,
	// Serial poll.
	input  wire logic       poll_req,
	output logic            poll_valid,
	output logic [7:0]      poll_byte,
	// Open-drain SRQ pin.
	input  wire logic       srq_in,
	output logic            srq_out,
	output logic            srq_oe,
	output logic            srq_line_active
);
	logic [1:0] rst_sync_reg;
	logic       rst_n;

	sbsr_byte_t summary;
	logic       mss;
	sbsr_byte_t mask_reg;
	sbsr_byte_t mask_next;
	logic       resp_valid_reg;
	logic       resp_valid_next;
	sbsr_byte_t resp_data_reg;
	sbsr_byte_t resp_data_next;
	logic       poll_valid_reg;
	logic       poll_valid_next;
	sbsr_byte_t poll_byte_reg;
	sbsr_byte_t poll_byte_next;
	logic [2:0] srq_sync_reg;
	logic [2:0] srq_sync_next;
	logic       srq_line_reg;
	logic       srq_line_next;

	// The status byte query and poll answers share the live summary and differ only in what bit 6 carries.
	function automatic sbsr_byte_t byte_with_bit6(input sbsr_byte_t sb, input logic b6);
		byte_with_bit6                = sb;
		byte_with_bit6[`SBSR_BIT_RQS] = b6;
	endfunction

	sbsr_if link ();

	// The reset is released through two flops so no flop leaves reset on a ragged edge.
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end

	assign rst_n = rst_sync_reg[1];

	// The summary bits are pure wiring; a cleared event register drops its bit at once.
	always_comb
	begin
		summary                    = 8'h00;
		summary[`SBSR_BIT_MEAS]    = meas_summary;
		summary[`SBSR_BIT_ERRQ]    = error_queue_nonempty;
		summary[`SBSR_BIT_QUES]    = questionable_summary;
		summary[`SBSR_BIT_RESP]    = response_pending;
		summary[`SBSR_BIT_STDEV]   = standard_event_summary;
		summary[`SBSR_BIT_OPER]    = operation_summary;
		mss                        = |sbsr_enabled(summary, mask_reg);
	end

	// Only a write or reset touches the mask; there is no other clear or preset input on purpose.
	always_comb
	begin
		if (sre_write)
			mask_next = sre_data & `SBSR_USED_MASK;
		else
			mask_next = mask_reg;
	end

	// A query answer reflects the state before any write in the same cycle.
	// When both queries arrive together the status byte wins.
	always_comb
	begin
		resp_valid_next = stb_query | sre_query;
		resp_data_next  = resp_data_reg;
		if (stb_query)
			resp_data_next = byte_with_bit6(summary, mss);
		else if (sre_query)
			resp_data_next = mask_reg;
	end

	// The poll byte carries the flag as it stood when the poll was taken.
	always_comb
	begin
		poll_valid_next = poll_req;
		poll_byte_next  = poll_byte_reg;
		if (poll_req)
			poll_byte_next = byte_with_bit6(summary, link.rqs);
	end

	// The line level passes three flops; a change counts once the last two agree.
	always_comb
	begin
		srq_sync_next = {srq_sync_reg[1:0], srq_in};
		if (srq_sync_reg[2] == srq_sync_reg[1])
			srq_line_next = ~srq_sync_reg[2];
		else
			srq_line_next = srq_line_reg;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mask_reg       <= `SBSR_MASK_RST;
			resp_valid_reg <= 1'b0;
			resp_data_reg  <= `SBSR_BYTE_RST;
			poll_valid_reg <= 1'b0;
			poll_byte_reg  <= `SBSR_BYTE_RST;
			srq_sync_reg   <= 3'h7;
			srq_line_reg   <= 1'b0;
		end
		else
		begin
			mask_reg       <= mask_next;
			resp_valid_reg <= resp_valid_next;
			resp_data_reg  <= resp_data_next;
			poll_valid_reg <= poll_valid_next;
			poll_byte_reg  <= poll_byte_next;
			srq_sync_reg   <= srq_sync_next;
			srq_line_reg   <= srq_line_next;
		end
	end

	assign link.summary   = summary;
	assign link.mask      = mask_reg;
	assign link.poll_done = poll_req;

	sbsr_rqs u_rqs (
		.mclk  (mclk),
		.rst_n (rst_n),
		.link  (link.rqs_side)
	);

	// SRQ is low-true and only ever pulled down; the line is released otherwise.
	assign srq_out         = 1'b0;
	assign srq_oe          = link.rqs;
	assign srq_line_active = srq_line_reg;
	assign resp_valid      = resp_valid_reg;
	assign resp_data       = resp_data_reg;
	assign poll_valid      = poll_valid_reg;
	assign poll_byte       = poll_byte_reg;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_mask_write;
		sre_write |=> mask_reg == ($past(sre_data) & 8'hBD);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("Mask write not stored.");

	property p_mask_hold;
		!sre_write |=> $stable(mask_reg);
	endproperty
	a_mask_hold: assert property (p_mask_hold) else $error("Mask changed without a write.");

	property p_stb_answer;
		stb_query |=> resp_valid && resp_data[7] == $past(operation_summary)
			&& resp_data[5] == $past(standard_event_summary) && resp_data[6] == $past(mss)
			&& resp_data[4] == $past(response_pending) && resp_data[3] == $past(questionable_summary)
			&& resp_data[2] == $past(error_queue_nonempty) && resp_data[0] == $past(meas_summary);
	endproperty
	a_stb_answer: assert property (p_stb_answer) else $error("Status byte answer wrong.");

	property p_sre_answer;
		sre_query && !stb_query |=> resp_valid && resp_data == $past(mask_reg);
	endproperty
	a_sre_answer: assert property (p_sre_answer) else $error("Mask answer wrong.");

	sequence s_poll_taken;
		poll_req && !link.rise;
	endsequence

	sequence s_poll_answered;
		poll_valid && poll_byte[6] == $past(link.rqs) && poll_byte[2] == $past(error_queue_nonempty)
			&& poll_byte[0] == $past(meas_summary) && poll_byte[7] == $past(operation_summary);
	endsequence

	property p_poll;
		s_poll_taken |=> s_poll_answered ##0 !srq_oe;
	endproperty
	a_poll: assert property (p_poll) else $error("Poll answer or release wrong.");

	property p_mss_kept;
		(poll_req && mss) ##1 ($stable(summary) && $stable(mask_reg)) |-> mss;
	endproperty
	a_mss_kept: assert property (p_mss_kept) else $error("Poll disturbed master summary.");

	property p_mss_value;
		mss == ((meas_summary && mask_reg[0]) || (error_queue_nonempty && mask_reg[2])
			|| (questionable_summary && mask_reg[3]) || (response_pending && mask_reg[4])
			|| (standard_event_summary && mask_reg[5]) || (operation_summary && mask_reg[7]));
	endproperty
	a_mss_value: assert property (p_mss_value) else $error("Master summary mismatch.");

	property p_bit1_zero;
		resp_data[1] == 1'b0 && poll_byte[1] == 1'b0 && mask_reg[1] == 1'b0;
	endproperty
	a_bit1_zero: assert property (p_bit1_zero) else $error("Unused bit 1 set.");

	property p_srq_on_rise;
		link.rise |=> srq_oe && srq_out == 1'b0;
	endproperty
	a_srq_on_rise: assert property (p_srq_on_rise) else $error("Rise did not drive SRQ.");

	property p_srq_hold;
		srq_oe && !poll_req |=> srq_oe;
	endproperty
	a_srq_hold: assert property (p_srq_hold) else $error("SRQ released without a poll.");

	property p_rearm;
		s_poll_taken ##1 link.rise |=> srq_oe && !srq_out;
	endproperty
	a_rearm: assert property (p_rearm) else $error("Request after a poll did not drive SRQ.");

	property p_resp_idle;
		!stb_query && !sre_query |=> !resp_valid && $stable(resp_data);
	endproperty
	a_resp_idle: assert property (p_resp_idle) else $error("Query answer moved without a query.");

	property p_poll_idle;
		!poll_req |=> !poll_valid && $stable(poll_byte);
	endproperty
	a_poll_idle: assert property (p_poll_idle) else $error("Poll answer moved without a poll.");

	property p_mask_zero;
		sre_write && sre_data == 8'h00 |=> mask_reg == 8'h00;
	endproperty
	a_mask_zero: assert property (p_mask_zero) else $error("Writing zero did not clear the mask.");

	property p_write_query_same;
		sre_write && sre_query && !stb_query |=> resp_data == $past(mask_reg)
			&& mask_reg == ($past(sre_data) & `SBSR_USED_MASK);
	endproperty
	a_write_query_same: assert property (p_write_query_same) else $error("Write with query mixed up.");

	property p_stb_first;
		stb_query && sre_query |=> resp_data[`SBSR_BIT_RQS] == $past(mss) && resp_data[1] == 1'b0;
	endproperty
	a_stb_first: assert property (p_stb_first) else $error("Status byte lost to mask query.");

	// The line view tracks the synchroniser, so a single glitch on the pin is never seen.
	property p_line_follow;
		srq_sync_reg[2] == srq_sync_reg[1] |=> srq_line_active == !$past(srq_sync_reg[2]);
	endproperty
	a_line_follow: assert property (p_line_follow) else $error("Line view did not follow the pin.");

	property p_line_hold;
		srq_sync_reg[2] != srq_sync_reg[1] |=> $stable(srq_line_active);
	endproperty
	a_line_hold: assert property (p_line_hold) else $error("Line view moved while unsettled.");

	// Watched without the reset guard, since the reset state itself is what is checked.
	property p_reset_state;
		disable iff (1'b0) !rst_n |-> mask_reg == `SBSR_MASK_RST && !srq_oe && !resp_valid && !poll_valid;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("State not cleared in reset.");
endmodule

// ---- tb/sbsr_ctrl_model.sv ----
// Bus controller model: resolves the open-drain SRQ wire and runs serial polls.
// Assumes the bench calls serial_poll and may add a second requester on the wire.
`timescale 1ns/1ps
module sbsr_ctrl_model
(
	// Clock.
	input  wire logic       mclk,
	// Second requester on the wire, driven by the bench.
	input  wire logic       other_req,
	// Device side.
	input  wire logic       srq_oe,
	input  wire logic       srq_out,
	input  wire logic       poll_valid,
	input  wire logic [7:0] poll_byte,
	output logic            poll_req,
	output logic            srq_in
);
	initial poll_req = 1'b0;

	// The wire has a pull-up, so it reads high whenever nobody pulls it down.
	assign srq_in = ((srq_oe && !srq_out) || other_req) ? 1'b0 : 1'b1;

	// Enable then disable gives one strobe; the byte is taken once the device talks, or after four cycles without an answer.
	task automatic serial_poll(output logic [7:0] b, output logic ok);
		int i;
		@(posedge mclk);
		#1;
		poll_req = 1'b1;
		@(posedge mclk);
		#1;
		poll_req = 1'b0;
		for (i = 0; i < 4 && poll_valid !== 1'b1; i++)
		begin
			@(posedge mclk);
			#1;
		end
		ok = (poll_valid === 1'b1);
		b = poll_byte;
	endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the status byte block with a polling controller model.
// Assumes a 100 MHz clock and the one-cycle command strobes of the block.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module testbench;
	import sbsr_pkg::*;
	logic       mclk = 1'b0;
	logic       arst_n = 1'b1;
	sbsr_byte_t sum = 8'h00;
	logic       sre_write = 1'b0;
	sbsr_byte_t sre_data = 8'h00;
	logic       sre_query = 1'b0;
	logic       stb_query = 1'b0;
	logic       other_req = 1'b0;
	logic       resp_valid, poll_valid, poll_req, srq_in, srq_out, srq_oe, srq_line_active, ok;
	sbsr_byte_t resp_data, poll_byte, b, m;
	int         n_errors = 0;
	int         checks = 0;
	int         seed = 32'h06e93960;
	int         k;

	always #5 mclk = ~mclk;

	sbsr_top dut (.mclk(mclk), .arst_n(arst_n), .meas_summary(sum[0]), .error_queue_nonempty(sum[2]),
		.questionable_summary(sum[3]), .response_pending(sum[4]), .standard_event_summary(sum[5]),
		.operation_summary(sum[7]), .sre_write(sre_write), .sre_data(sre_data), .sre_query(sre_query),
		.stb_query(stb_query), .resp_valid(resp_valid), .resp_data(resp_data), .poll_req(poll_req),
		.poll_valid(poll_valid), .poll_byte(poll_byte), .srq_in(srq_in), .srq_out(srq_out),
		.srq_oe(srq_oe), .srq_line_active(srq_line_active));

	sbsr_ctrl_model ctl (.mclk(mclk), .other_req(other_req), .srq_oe(srq_oe), .srq_out(srq_out),
		.poll_valid(poll_valid), .poll_byte(poll_byte), .poll_req(poll_req), .srq_in(srq_in));

	function automatic sbsr_byte_t exp_stb(input sbsr_byte_t s, input sbsr_byte_t msk);
		exp_stb = (s & 8'hBD) | ((|(s & msk & 8'hBD)) ? 8'h40 : 8'h00);
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic final_report();
		$display("errors %0d, checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic set_mask(input sbsr_byte_t v);
		tick(1);
		sre_write = 1'b1;
		sre_data = v;
		tick(1);
		sre_write = 1'b0;
	endtask

	task automatic query(input logic stb, input sbsr_byte_t want);
		tick(1);
		stb_query = stb;
		sre_query = !stb;
		tick(1);
		stb_query = 1'b0;
		sre_query = 1'b0;
		`CHK(resp_valid, 1'b1)
		`CHK(resp_data, want)
	endtask

	// Bounded, since a flag that never moves would otherwise hang the run.
	task automatic wait_oe(input logic v);
		int i;
		for (i = 0; i < 6 && srq_oe !== v; i++)
			tick(1);
		`CHK(srq_oe, v)
		`CHK(srq_out, 1'b0)
		if (srq_oe !== v)
			final_report();
	endtask

	task automatic poll(output sbsr_byte_t got);
		ctl.serial_poll(got, ok);
		if (!ok)
		begin
			n_errors++;
			final_report();
		end
	endtask

	initial
	begin
		#1;
		arst_n = 1'b0;
		tick(12);
		arst_n = 1'b1;
		tick(3);
		query(1'b0, 8'h00);
		query(1'b1, 8'h00);
		for (k = 0; k < 8; k++)
		begin
			if (k == 1 || k == 6)
				continue;
			set_mask(8'h01 << k);
			sum = 8'h01 << k;
			wait_oe(1'b1);
			poll(b);
			`CHK(b, sum | 8'h40)
			wait_oe(1'b0);
			query(1'b1, sum | 8'h40);
			sum = 8'h00;
			query(1'b1, 8'h00);
			sum = 8'h01 << k;
			wait_oe(1'b1);
			poll(b);
			`CHK(b, sum | 8'h40)
		end
		set_mask(8'h02);
		query(1'b0, 8'h00);
		for (k = 0; k < 40; k++)
		begin
			m = sbsr_byte_t'($random(seed));
			set_mask(m);
			sum = sbsr_byte_t'($random(seed));
			query(1'b0, m & 8'hBD);
			query(1'b1, exp_stb(sum, m));
		end
		set_mask(8'h00);
		poll(b);
		`CHK(b & 8'hBF, sum & 8'hBD)
		wait_oe(1'b0);
		query(1'b0, 8'h00);
		other_req = 1'b1;
		tick(6);
		`CHK(srq_line_active, 1'b1)
		other_req = 1'b0;
		tick(6);
		`CHK(srq_line_active, 1'b0)
		sum = 8'h00;
		set_mask(8'hFF);
		arst_n = 1'b0;
		tick(2);
		arst_n = 1'b1;
		tick(3);
		query(1'b0, 8'h00);
		`CHK(srq_oe, 1'b0)
		final_report();
	end
endmodule
